// *** logic/hpm_map.vh ***
// Address map, mode and edge codes, reset values and timing figures for the
// haptic playback mode controller.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef HPM_MAP_VH
`define HPM_MAP_VH
`define HPM_OFF_CTRL      12'h000
`define HPM_OFF_LEVEL     12'h004
`define HPM_OFF_SEQ       12'h008
`define HPM_OFF_GPI       12'h00c
`define HPM_OFF_STATUS    12'h010
`define HPM_OFF_OUT       12'h014
`define HPM_CTRL_RESET    32'h00000000
`define HPM_GPI_RESET     32'h00000000
`define HPM_MODE_INACTIVE 3'h0
`define HPM_MODE_REG      3'h1
`define HPM_MODE_PWM      3'h2
`define HPM_MODE_RTRIG    3'h3
`define HPM_MODE_ETRIG    3'h4
`define HPM_EDGE_RISE     2'h0
`define HPM_EDGE_FALL     2'h1
`define HPM_EDGE_BOTH     2'h2
`define HPM_HALF_PER_NS   2000000
`define HPM_CLK_NS        4
`define HPM_FRAME_NS      4000000
`endif

// *** logic/hpm_top.v ***
// Playback mode control: mode select, level streaming from a register or a
// PWM pin, stored-sequence triggering by register or by GPI edges.
// Assumes an APB master on clk and asynchronous GPI/PWM pins.
// Function
// [R1] Mode zero idles in chosen standby state
// [R2] Modes one, two stream register or PWM
// [R3] Mode three register start, four adds edges
// [R4] Leave inactive only when faults cleared
// [R5] Fault stops playback, forces low-power idle
// [R6] Overdrive on: 0x00-0x7F scale nominal max
// [R7] Steady level scales nominal maximum
// [R8] Overdrive off: signed level scales absolute
// [R9] Negative level flips polarity or phase
// [R10] Braking stays usable without overdrive
// [R11] Sample level only at half periods
// [R12] Level writes lag one half period
// [R13] Zero level disables stage, re-enable later
// [R14] Duty scales nominal or signed absolute
// [R15] Output rate independent of PWM rate
// [R16] Rising-edge demodulator with minimum duty
// [R17] Index, repeats, start bit, done interrupt
// [R18] Replay bit repeats without going inactive
// [R19] Per-pin rising, falling or both edges
// [R20] Further event stops edge playback
// [R21] Alternate mode toggles index plus one
// [R22] Edge playback ends with interrupt, idle
// [R23] Completion enters idle or standby
// [R24] Pins pass two flip-flops first
`include "hpm_map.vh"
module hpm_top #(
  parameter HALF_CYC  = `HPM_HALF_PER_NS / `HPM_CLK_NS,
  parameter FRAME_CYC = `HPM_FRAME_NS / `HPM_CLK_NS,
  parameter PWM_W     = 24
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  trigger_input,
  input  wire        fault_in,
  output reg  [8:0]  drive_level_r,
  output reg         drive_enable_r,
  output reg         drive_polarity_r,
  output reg         standby_r,
  output reg         seq_active_r,
  output reg  [7:0]  seq_index_r,
  output reg         interrupt_out_n
);
  localparam S_IDLE = 4'b0001;
  localparam S_STBY = 4'b0010;
  localparam S_STRM = 4'b0100;
  localparam S_SEQ  = 4'b1000;

  reg [31:0] ctrl_r, gpi_cfg_r;
  reg [7:0]  streamed_level_value, min_duty_threshold;
  reg [7:0]  selected_sequence_index;
  reg [3:0]  sequence_repeat_count;
  reg        sequence_replay_bit, sequence_finished_flag, fault_flag_r;
  reg [3:0]  state_r;
  reg [1:0]  sync_a_r [0:2];
  reg [2:0]  pin_r, pin_d_r;
  reg [2:0]  alt_phase_r;
  reg [PWM_W-1:0] per_cnt_r, hi_cnt_r, period_r, high_r;
  reg [7:0]  duty_r;
  reg [31:0] half_cnt_r, frame_cnt_r;
  reg [3:0]  loops_left_r;
  reg        edge_started_r, go_r;
  reg [8:0]  target_r;
  integer    i;

  wire [2:0] mode   = ctrl_r[2:0];
  wire       stby_en = ctrl_r[4];
  wire       od_en  = ctrl_r[5];
  wire       apb_wr = psel & penable & pwrite & pready;
  wire       half_tick = (half_cnt_r == 32'h0);

  // Edge event per pin, chosen by that pin's two-bit select field.
  function ev_of;
    input [1:0] sel;
    input       cur;
    input       prv;
    begin
      case (sel)
        `HPM_EDGE_RISE: ev_of = cur & ~prv;
        `HPM_EDGE_FALL: ev_of = ~cur & prv;
        `HPM_EDGE_BOTH: ev_of = cur ^ prv;
        default:        ev_of = 1'b0;
      endcase
    end
  endfunction

  // [R19] Edge select per pin.
  wire [2:0] pin_ev;
  assign pin_ev[0] = ev_of(gpi_cfg_r[1:0],   pin_r[0], pin_d_r[0]);
  assign pin_ev[1] = ev_of(gpi_cfg_r[11:10], pin_r[1], pin_d_r[1]);
  assign pin_ev[2] = ev_of(gpi_cfg_r[21:20], pin_r[2], pin_d_r[2]);
  wire any_ev = |pin_ev & (mode == `HPM_MODE_ETRIG);

  // [R24] Two-stage pin synchroniser; only the second stage is read.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 3; i = i + 1)
        sync_a_r[i] <= 2'b00;
      pin_r   <= 3'b000;
      pin_d_r <= 3'b000;
    end else begin
      for (i = 0; i < 3; i = i + 1)
        sync_a_r[i] <= {sync_a_r[i][0], trigger_input[i]};
      pin_r   <= {sync_a_r[2][1], sync_a_r[1][1], sync_a_r[0][1]};
      pin_d_r <= pin_r;
    end
  end

  // [R16] Duty measured rising edge to rising edge on pin zero.
  // [R15] The period only feeds the ratio, never the output rate.
  wire pwm_rise = pin_r[0] & ~pin_d_r[0];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt_r <= {PWM_W{1'b0}};
      hi_cnt_r  <= {PWM_W{1'b0}};
      period_r  <= {PWM_W{1'b0}};
      high_r    <= {PWM_W{1'b0}};
    end else if (pwm_rise) begin
      period_r  <= per_cnt_r;
      high_r    <= hi_cnt_r;
      per_cnt_r <= {{(PWM_W-1){1'b0}}, 1'b1};
      hi_cnt_r  <= {{(PWM_W-1){1'b0}}, 1'b1};
    end else begin
      if (~&per_cnt_r)
        per_cnt_r <= per_cnt_r + 1'b1;
      if (pin_r[0] && ~&hi_cnt_r)
        hi_cnt_r <= hi_cnt_r + 1'b1;
    end
  end

  // Duty in 256ths so that half duty lands on 128, the signed zero.
  // A serial divide would save area; the ratio changes slowly.
  wire [PWM_W+7:0] duty_w = (period_r == {PWM_W{1'b0}}) ? {(PWM_W+8){1'b0}}
                          : {high_r, 8'h00} / period_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      duty_r <= 8'h00;
    else
      duty_r <= (|duty_w[PWM_W+7:8]) ? 8'hff : duty_w[7:0];
  end

  // Requested level: nine-bit signed, full scale 127 toward the stage.
  // [R6] [R8] [R14] Interpretation depends on the overdrive bit.
  reg [8:0] req_lvl;
  always @* begin
    req_lvl = 9'h000;
    if (mode == `HPM_MODE_REG) begin
      if (od_en)
        req_lvl = streamed_level_value[7] ? 9'h000
                : {2'b00, streamed_level_value[6:0]};
      else
        req_lvl = {streamed_level_value[7], streamed_level_value};
    end else if (mode == `HPM_MODE_PWM) begin
      if (duty_r < min_duty_threshold)
        req_lvl = 9'h000;
      else if (od_en)
        req_lvl = {2'b00, duty_r[7:1]};
      else
        req_lvl = {1'b0, duty_r} - 9'h080;
    end
  end

  // Register bus: zero-wait writes and reads; unmapped reads and writes give error.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r    <= `HPM_CTRL_RESET;
      gpi_cfg_r <= `HPM_GPI_RESET;
      streamed_level_value    <= 8'h00;
      min_duty_threshold      <= 8'h00;
      selected_sequence_index <= 8'h00;
      sequence_repeat_count   <= 4'h0;
      sequence_replay_bit     <= 1'b0;
      go_r    <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      go_r    <= 1'b0;
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          `HPM_OFF_CTRL:   prdata <= ctrl_r;
          `HPM_OFF_LEVEL:  prdata <= {16'h0, min_duty_threshold,
                                      streamed_level_value};
          `HPM_OFF_SEQ:    prdata <= {18'h0, sequence_replay_bit, 1'b0,
                                      sequence_repeat_count,
                                      selected_sequence_index};
          `HPM_OFF_GPI:    prdata <= gpi_cfg_r;
          `HPM_OFF_STATUS: prdata <= {26'h0, state_r, fault_flag_r,
                                      sequence_finished_flag};
          `HPM_OFF_OUT:    prdata <= {21'h0, drive_polarity_r,
                                      drive_enable_r, drive_level_r};
          default:         pslverr <= 1'b1;
        endcase
        if (paddr > `HPM_OFF_OUT || paddr[1:0] != 2'b00)
          pslverr <= 1'b1;
      end
      if (apb_wr) begin
        case (paddr)
          `HPM_OFF_CTRL:  ctrl_r <= pwdata;
          `HPM_OFF_LEVEL: begin
            streamed_level_value <= pwdata[7:0];
            min_duty_threshold   <= pwdata[15:8];
          end
          `HPM_OFF_SEQ: begin
            selected_sequence_index <= pwdata[7:0];
            sequence_repeat_count   <= pwdata[11:8];
            // [R17] Writing one to the go bit starts a sequence.
            go_r                <= pwdata[12];
            sequence_replay_bit <= pwdata[13];
          end
          `HPM_OFF_GPI:   gpi_cfg_r <= pwdata;
          default:        ;
        endcase
      end
    end
  end

  // Sticky flags: hardware set wins over a write-one clear.
  wire clr_w = apb_wr && (paddr == `HPM_OFF_STATUS);
  wire seq_end = (state_r == S_SEQ) && (frame_cnt_r == 32'h1)
                 && (loops_left_r == 4'h0) && !sequence_replay_bit;
  wire stop_ev = (state_r == S_SEQ) && edge_started_r && any_ev;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sequence_finished_flag <= 1'b0;
      fault_flag_r <= 1'b0;
    end else begin
      sequence_finished_flag <= (seq_end | stop_ev) |
        (sequence_finished_flag & ~(clr_w & pwdata[0]));
      fault_flag_r <= fault_in | (fault_flag_r & ~(clr_w & pwdata[1]));
    end
  end

  // Start request from the bus or, in edge mode, from a pin.
  // [R3] Register start in modes three/four, pin edges in four only.
  wire bus_go  = go_r && (mode == `HPM_MODE_RTRIG ||
                          mode == `HPM_MODE_ETRIG);
  wire idle_st = (state_r == S_IDLE) || (state_r == S_STBY);
  wire stream  = (mode == `HPM_MODE_REG) || (mode == `HPM_MODE_PWM);
  reg [7:0] pin_idx;
  always @* begin
    pin_idx = gpi_cfg_r[9:2];
    if (pin_ev[1] && !pin_ev[0])
      pin_idx = gpi_cfg_r[19:12];
    else if (pin_ev[2] && !pin_ev[0] && !pin_ev[1])
      pin_idx = gpi_cfg_r[29:22];
  end
  wire [1:0] pin_no = pin_ev[0] ? 2'd0 : (pin_ev[1] ? 2'd1 : 2'd2);

  // Main playback state machine.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r        <= S_IDLE;
      frame_cnt_r    <= 32'h0;
      loops_left_r   <= 4'h0;
      edge_started_r <= 1'b0;
      seq_index_r    <= 8'h00;
      alt_phase_r    <= 3'b000;
      seq_active_r   <= 1'b0;
      standby_r      <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE, S_STBY: begin
          // [R1] Wait in the state chosen by the standby bit.
          // [R5] A latched fault holds low-power idle until cleared.
          state_r <= (stby_en && !fault_flag_r) ? S_STBY : S_IDLE;
          // [R4] Faults must be cleared before leaving inactive.
          if (!fault_flag_r && !fault_in) begin
            if (stream)
              state_r <= S_STRM;
            else if (bus_go || (idle_st && any_ev)) begin
              state_r        <= S_SEQ;
              frame_cnt_r    <= FRAME_CYC;
              loops_left_r   <= sequence_repeat_count;
              edge_started_r <= !bus_go;
              seq_index_r    <= selected_sequence_index;
              if (!bus_go) begin
                // [R21] Alternate mode plays index plus one on even events.
                seq_index_r <= pin_idx +
                  {7'h0, alt_phase_r[pin_no] & gpi_cfg_r[10*pin_no+9]};
                if (gpi_cfg_r[10*pin_no+9])
                  alt_phase_r[pin_no] <= ~alt_phase_r[pin_no];
              end
            end
          end
        end
        S_STRM: begin
          // [R2] Stream while mode one or two is held.
          if (!stream)
            state_r <= stby_en ? S_STBY : S_IDLE;
        end
        S_SEQ: begin
          if (frame_cnt_r != 32'h0)
            frame_cnt_r <= frame_cnt_r - 32'h1;
          // [R20] A later pin event stops edge playback.
          if (stop_ev)
            state_r <= stby_en ? S_STBY : S_IDLE;
          else if (frame_cnt_r == 32'h1) begin
            if (loops_left_r != 4'h0) begin
              loops_left_r <= loops_left_r - 4'h1;
              frame_cnt_r  <= FRAME_CYC;
            end else if (sequence_replay_bit) begin
              // [R18] Replay without passing through inactive.
              loops_left_r <= sequence_repeat_count;
              frame_cnt_r  <= FRAME_CYC;
            end else
              // [R23] [R22] Completion goes to idle or standby.
              state_r <= stby_en ? S_STBY : S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
      // [R5] Any fault forces low-power idle regardless of standby.
      if (fault_in)
        state_r <= S_IDLE;
      seq_active_r <= (state_r == S_SEQ);
      standby_r    <= (state_r == S_STBY);
    end
  end

  // Half-period timebase, free of the input PWM rate.
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      half_cnt_r <= 32'h0;
    else if (half_tick)
      half_cnt_r <= HALF_CYC - 1;
    else
      half_cnt_r <= half_cnt_r - 32'h1;
  end

  // [R11] [R12] Level sampled only at half-period ticks.
  // [R13] Zero level disables the stage; re-enable waits a tick.
  // [R9] Sign becomes polarity; [R7] [R10] braking lives downstream.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      target_r         <= 9'h000;
      drive_level_r    <= 9'h000;
      drive_enable_r   <= 1'b0;
      drive_polarity_r <= 1'b0;
      interrupt_out_n  <= 1'b1;
    end else begin
      if (half_tick) begin
        target_r         <= (state_r == S_STRM) ? req_lvl : 9'h000;
        drive_level_r    <= target_r[8] ? (9'h000 - target_r) : target_r;
        // Polarity is the sign itself, so the host can poll it.
        drive_polarity_r <= target_r[8];
        drive_enable_r   <= (target_r != 9'h000) || (state_r == S_SEQ);
      end
      if (fault_in || !(state_r == S_STRM || state_r == S_SEQ)) begin
        drive_enable_r <= 1'b0;
        drive_level_r  <= 9'h000;
      end
      // [R17] Interrupt low while the done flag stands.
      interrupt_out_n <= ~sequence_finished_flag;
    end
  end
endmodule

// *** sim/hpm_sva.sv ***
// Port checker for the playback mode controller.
// Assumes one clock domain and an APB master on clk.
module hpm_sva #(
  parameter HALF_CYC  = 500000,
  parameter FRAME_CYC = 1000000
) (
  input wire        clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        fault_in,
  input wire [8:0]  drive_level_r,
  input wire        drive_enable_r,
  input wire        standby_r,
  input wire        seq_active_r,
  input wire        interrupt_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  reg [31:0] gap_r;
  reg       flt_r;
  // Gap saturates so a long idle cannot wrap; fault copy clears on W1C.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 32'h0;
      flt_r <= 1'b0;
    end else begin
      gap_r <= $changed(drive_level_r) ? 32'h0
             : gap_r + {31'h0, gap_r != 32'hffffffff};
      if (fault_in)
        flt_r <= 1'b1;
      else if (psel && penable && pwrite && paddr == 12'h010 && pwdata[1])
        flt_r <= 1'b0;
    end
  end
  sequence s_quiet;
    !seq_active_r && !drive_enable_r && !standby_r;
  endsequence
  pready_one_a: assert property (psel && !penable |=> pready)
    else $error("pready late");
  slverr_qual_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  fault_stop_a: assert property (
    $rose(fault_in) |-> ##[1:4] s_quiet)
    else $error("fault did not stop playback");
  no_start_a: assert property (
    ($rose(seq_active_r) || $rose(drive_enable_r)) |-> !flt_r)
    else $error("start with fault pending");
  level_tick_a: assert property (
    ($changed(drive_level_r) && drive_level_r != 9'h000 &&
     $past(drive_level_r) != 9'h000) |-> gap_r >= HALF_CYC - 1)
    else $error("level moved off the half period");
  zero_off_a: assert property (
    drive_enable_r && drive_level_r == 9'h000 |-> seq_active_r)
    else $error("stage left on at zero");
  irq_cause_a: assert property (
    $fell(interrupt_out_n) |-> $past(seq_active_r) || $past(seq_active_r, 2))
    else $error("interrupt without playback");
  standby_idle_a: assert property (
    standby_r |-> !seq_active_r && !drive_enable_r)
    else $error("standby while driving");
endmodule

bind hpm_top hpm_sva #(.HALF_CYC(HALF_CYC), .FRAME_CYC(FRAME_CYC)) u_sva (
  .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .fault_in, .drive_level_r, .drive_enable_r, .standby_r,
  .seq_active_r, .interrupt_out_n);

// *** sim/hpm_host_pins.sv ***
// Host-side pin model: trigger levels and a PWM stream on pin zero.
// Assumes the bench gives the duty in 64ths of a period.
module hpm_host_pins (
  input  wire       pwm_on,
  input  wire [5:0] duty,
  input  wire [2:0] lvl,
  output wire [2:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;
  reg       lclk;
  reg [5:0] ph_r;
  // The stream clock stops between streams, as a real source would.
  initial begin
    lclk = 1'b0;
    ph_r = 6'h00;
    #1.3;
    forever #24 lclk = pwm_on ? ~lclk : 1'b0;
  end
  always @(posedge lclk) ph_r <= ph_r + 6'h01;
  assign pins = pwm_on ? {lvl[2:1], ph_r < duty} : lvl;
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the playback mode controller.
// Assumes shortened half-period and frame counts.
`include "hpm_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam HC = 20;
  localparam FC = 50;
  localparam W = 2 * HC + 4;
  reg         clk, resetn, psel, penable, pwrite, fault_in, pwm_on, er;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [5:0]  duty;
  reg  [2:0]  lvl;
  wire [31:0] prdata;
  wire        pready, pslverr, en, pol, sb, act, irq;
  wire [8:0]  lv;
  wire [7:0]  idx;
  wire [2:0]  pins;
  integer     err_count, n_compared;
  integer     cyc = 0;
  hpm_top #(.HALF_CYC(HC), .FRAME_CYC(FC)) DUT (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trigger_input(pins), .fault_in,
    .drive_level_r(lv), .drive_enable_r(en), .drive_polarity_r(pol),
    .standby_r(sb), .seq_active_r(act), .seq_index_r(idx),
    .interrupt_out_n(irq));
  hpm_host_pins HOST (.pwm_on, .duty, .lvl, .pins);
  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      if (err_count == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // The request holds until pready is seen high at an edge.
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wact(input v, input integer lim);
    repeat (lim) if (act !== v) @(posedge clk);
  endtask
  task ev(input [2:0] v, input a);
    begin
      lvl <= v;
      wt(8);
      chk("act", a, act);
    end
  endtask
  task pwm(input [31:0] c, input [5:0] d, input e, input p);
    begin
      apb(1, `HPM_OFF_CTRL, c);
      duty <= d;
      wt(2400);
      chk("en", e, en);
      if (e) chk("pol", p, pol);
    end
  endtask
  task t_regs;
    begin
      apb(0, `HPM_OFF_CTRL, 32'h0);
      chk("ctrl", `HPM_CTRL_RESET, rd);
      chk("irq", 1'b1, irq);
      apb(0, 12'h018, 32'h0);
      chk("err", 1'b1, er);
      apb(1, 12'h002, 32'h21);
      chk("err", 1'b1, er);
      apb(1, `HPM_OFF_CTRL, 32'h10);
      wt(4);
      chk("sb", 1'b1, sb);
      apb(1, `HPM_OFF_CTRL, 32'h0);
      wt(4);
      chk("sb", 1'b0, sb);
    end
  endtask
  task t_dro;
    begin
      apb(1, `HPM_OFF_LEVEL, 32'h40);
      apb(1, `HPM_OFF_CTRL, 32'h21);
      wt(W);
      chk("lvl", 32'h40, lv);
      chk("pol", 1'b0, pol);
      apb(1, `HPM_OFF_CTRL, 32'h01);
      apb(1, `HPM_OFF_LEVEL, 32'h80);
      wt(W);
      chk("lvl", 32'h80, lv);
      chk("pol", 1'b1, pol);
      apb(1, `HPM_OFF_LEVEL, 32'h0);
      wt(W);
      chk("en", 1'b0, en);
      apb(1, `HPM_OFF_LEVEL, 32'h7f);
      wt(W);
      chk("en", 1'b1, en);
      chk("lvl", 32'h7f, lv);
      apb(1, `HPM_OFF_CTRL, 32'h0);
      wt(W);
      chk("en", 1'b0, en);
    end
  endtask
  task t_pwm;
    begin
      apb(1, `HPM_OFF_LEVEL, 32'h2000);
      pwm_on <= 1'b1;
      pwm(32'h02, 6'h30, 1'b1, 1'b0);
      pwm(32'h02, 6'h10, 1'b1, 1'b1);
      pwm(32'h02, 6'h20, 1'b0, 1'b0);
      pwm(32'h22, 6'h04, 1'b0, 1'b0);
      pwm(32'h22, 6'h30, 1'b1, 1'b0);
      apb(1, `HPM_OFF_CTRL, 32'h0);
      pwm_on <= 1'b0;
    end
  endtask
  task t_rtrig;
    begin
      apb(1, `HPM_OFF_CTRL, 32'h13);
      ev(3'h7, 1'b0);
      ev(3'h0, 1'b0);
      apb(1, `HPM_OFF_SEQ, 32'h1005);
      wact(1'b1, 10);
      chk("idx", 32'h5, idx);
      wact(1'b0, 4 * FC);
      chk("irq", 1'b0, irq);
      chk("sb", 1'b1, sb);
      apb(0, `HPM_OFF_STATUS, 32'h0);
      chk("done", 32'h1, rd & 32'h1);
      apb(1, `HPM_OFF_STATUS, 32'h1);
      wt(2);
      chk("irq", 1'b1, irq);
      apb(1, `HPM_OFF_CTRL, 32'h03);
      apb(1, `HPM_OFF_SEQ, 32'h3006);
      wt(FC + FC / 2);
      chk("act", 1'b1, act);
      apb(1, `HPM_OFF_SEQ, 32'h0006);
      wact(1'b0, 4 * FC);
      chk("act", 1'b0, act);
      chk("sb", 1'b0, sb);
      apb(1, `HPM_OFF_STATUS, 32'h3);
    end
  endtask
  task t_etrig;
    begin
      apb(1, `HPM_OFF_GPI, 32'h2c220440);
      ev(3'h2, 1'b0);
      apb(0, `HPM_OFF_GPI, 32'h0);
      chk("gpi", 32'h2c220440, rd);
      apb(1, `HPM_OFF_CTRL, 32'h04);
      ev(3'h3, 1'b1);
      chk("idx", 32'h10, idx);
      ev(3'h1, 1'b0);
      apb(1, `HPM_OFF_STATUS, 32'h1);
      ev(3'h0, 1'b0);
      ev(3'h2, 1'b0);
      ev(3'h0, 1'b1);
      chk("idx", 32'h20, idx);
      wact(1'b0, 4 * FC);
      chk("irq", 1'b0, irq);
      chk("sb", 1'b0, sb);
      ev(3'h4, 1'b1);
      chk("idx", 32'hb0, idx);
      wact(1'b0, 4 * FC);
      ev(3'h0, 1'b1);
      chk("idx", 32'hb1, idx);
      wact(1'b0, 4 * FC);
      apb(1, `HPM_OFF_STATUS, 32'h3);
    end
  endtask
  task t_fault;
    begin
      apb(1, `HPM_OFF_CTRL, 32'h13);
      apb(1, `HPM_OFF_SEQ, 32'h1001);
      wact(1'b1, 10);
      fault_in <= 1'b1;
      wt(1);
      fault_in <= 1'b0;
      wt(4);
      chk("act", 1'b0, act);
      chk("sb", 1'b0, sb);
      apb(1, `HPM_OFF_SEQ, 32'h1001);
      wt(8);
      chk("act", 1'b0, act);
      apb(1, `HPM_OFF_STATUS, 32'h3);
      apb(1, `HPM_OFF_SEQ, 32'h1001);
      wact(1'b1, 10);
      chk("act", 1'b1, act);
      wact(1'b0, 4 * FC);
    end
  endtask
  // Reset, then each scenario in turn.
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fault_in = 1'b0;
    pwm_on = 1'b0;
    duty = 6'h00;
    lvl = 3'h0;
    err_count = 0;
    n_compared = 0;
    wt(10);
    resetn <= 1'b1;
    t_regs;
    t_dro;
    t_pwm;
    t_rtrig;
    t_etrig;
    t_fault;
    finish_test;
  end
endmodule
